// File: rtl/sfmp_top.sv
// Forwarding and MAC policy register bank with frame decision logic.
`timescale 1ns/1ns
// Overview of operation
// - Unknown VLAN frames dropped when disabled.
// - Enabled: forward only to masked ports.
// - Precedence: VLAN, then unicast, then multicast.
// - Alternate back-off affects half duplex only.
// - Drop after sixteen collisions unless disabled.
// - Length check discards mismatched short-type frames.
// - Drop mode set: drop either pause match.
// - Drop mode clear: drop only both matches.
// - Aggressive back-off on half duplex when set.
module sfmp_top (
	// APB clock and reset.
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave.
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Ingress frame descriptors and decisions.
	input  sfmp_pkg::sfmp_frame_t    frame,
	output sfmp_pkg::sfmp_dec_t      dec,
	// Port state from the MACs, per port 1 to 3.
	input  wire logic [2:0]          half_duplex,
	input  wire logic [14:0]         coll_count,
	// Per-port MAC controls.
	output sfmp_pkg::sfmp_mac_t [2:0] mac
);
	typedef struct packed {
		logic [7:0]          ctrl0;
		logic [31:0]         unk_vlan;
		logic [7:0]          ctrl1;
		logic [31:0]         rdata;
		logic                ready;
		logic                slverr;
		logic [15:0]         drop_count;
		sfmp_pkg::sfmp_dec_t dec;
	} sfmp_state_t;

	sfmp_state_t state;
	sfmp_state_t next_state;

	// Bus phases.
	logic                setup;
	logic                access;

	// Address decode and write enables.
	logic                hit_ctrl0;
	logic                hit_unk_vlan;
	logic                hit_ctrl1;
	logic                hit_status;
	logic                hit_any;
	logic                rd_err;
	logic                wr_ctrl0;
	logic                wr_unk_vlan;
	logic                wr_ctrl1;
	logic [31:0]         wr_data;
	logic [31:0]         rd_word;

	// Register fields as the policy logic sees them.
	logic                fwd_en;
	logic [2:0]          fwd_mask;
	logic                len_check_en;
	logic                fc_drop_mode;
	logic                alt_backoff;
	logic                aggr_backoff;
	logic                no_exc_drop;

	// Per-port views of the packed MAC inputs.
	logic [4:0]          coll_p1;
	logic [4:0]          coll_p2;
	logic [4:0]          coll_p3;
	logic                hd_p1;
	logic                hd_p2;
	logic                hd_p3;

	// Frame classification and policy.
	logic                pause_type;
	logic                pause_da;
	logic                fc_drop;
	logic                short_type;
	logic                len_mismatch;
	logic                len_bad;
	logic                vlan_drop;
	logic                frame_drop;
	sfmp_pkg::sfmp_cls_t frame_cls;
	logic [2:0]          frame_mask;
	sfmp_pkg::sfmp_dec_t frame_dec;

	// The answer comes in the cycle after setup, so the bus needs no wait logic.
	assign setup  = psel && !penable;
	assign access = psel && penable && state.ready;

	// One decoder serves the read mux, the write enables and the error flag.
	assign hit_ctrl0    = paddr == sfmp_pkg::ADDR_MAC_CTRL0;
	assign hit_unk_vlan = paddr == sfmp_pkg::ADDR_UNK_VLAN;
	assign hit_ctrl1    = paddr == sfmp_pkg::ADDR_MAC_CTRL1;
	assign hit_status   = paddr == sfmp_pkg::ADDR_STATUS;
	assign hit_any      = hit_ctrl0 || hit_unk_vlan
		|| hit_ctrl1 || hit_status;
	assign rd_err       = !hit_any;

	// A write lands only at the edge that closes the access phase.
	assign wr_ctrl0    = access && pwrite && hit_ctrl0 && pstrb[0];
	assign wr_unk_vlan = access && pwrite && hit_unk_vlan;
	assign wr_ctrl1    = access && pwrite && hit_ctrl1 && pstrb[0];

	// Byte lanes without a strobe keep their old contents.
	always_comb begin
		wr_data = pwdata;
		for (int i = 0; i < 4; i++) begin
			if (!pstrb[i]) begin
				wr_data[i*8 +: 8] = state.unk_vlan[i*8 +: 8];
			end
		end
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		rd_word = 32'h00000000;
		if (hit_ctrl0) begin
			rd_word = {24'h000000, state.ctrl0};
		end
		if (hit_unk_vlan) begin
			rd_word = state.unk_vlan & sfmp_pkg::UNK_VLAN_WMASK;
		end
		if (hit_ctrl1) begin
			rd_word = {24'h000000, state.ctrl1};
		end
		if (hit_status) begin
			rd_word = {16'h0000, state.drop_count};
		end
	end

	// Register fields.
	assign fwd_en       = state.unk_vlan[sfmp_pkg::BIT_UNK_VLAN_EN];
	assign fwd_mask     = state.unk_vlan[2:0];
	assign len_check_en = state.ctrl0[sfmp_pkg::BIT_LEN_CHECK];
	assign fc_drop_mode = state.ctrl0[sfmp_pkg::BIT_FC_DROP_MODE];
	assign alt_backoff  = state.ctrl0[sfmp_pkg::BIT_ALT_BACKOFF];
	assign aggr_backoff = state.ctrl0[sfmp_pkg::BIT_AGGR_BACKOFF];
	assign no_exc_drop  = state.ctrl1[sfmp_pkg::BIT_NO_EXC_DROP];

	// Bit p of the duplex bus and field p of the collision bus belong to port p+1.
	assign hd_p1   = half_duplex[0];
	assign hd_p2   = half_duplex[1];
	assign hd_p3   = half_duplex[2];
	assign coll_p1 = coll_count[4:0];
	assign coll_p2 = coll_count[9:5];
	assign coll_p3 = coll_count[14:10];

	assign pause_type = frame.type_len == sfmp_pkg::PAUSE_ETHERTYPE;
	assign pause_da   = frame.da == sfmp_pkg::PAUSE_DA;
	assign fc_drop    = fc_drop_mode ? (pause_type || pause_da)
		: (pause_type && pause_da);

	assign short_type   = frame.type_len < sfmp_pkg::LEN_FIELD_LIMIT;
	assign len_mismatch = frame.act_len != frame.type_len;
	assign len_bad      = len_check_en && short_type && len_mismatch;

	always_comb begin
		frame_cls = sfmp_pkg::SFMP_CLS_NORMAL;
		if (frame.unk_vlan) begin
			frame_cls = sfmp_pkg::SFMP_CLS_UNK_VLAN;
		end else if (frame.unk_ucast) begin
			frame_cls = sfmp_pkg::SFMP_CLS_UNK_UCAST;
		end else if (frame.unk_mcast) begin
			frame_cls = sfmp_pkg::SFMP_CLS_UNK_MCAST;
		end
	end

	assign vlan_drop  = frame_cls == sfmp_pkg::SFMP_CLS_UNK_VLAN && !fwd_en;
	assign frame_drop = fc_drop || len_bad || vlan_drop;

	// Unicast and multicast policies live downstream; this block only classifies them.
	always_comb begin
		frame_mask = 3'h7;
		unique case (frame_cls)
			sfmp_pkg::SFMP_CLS_UNK_VLAN: begin
				frame_mask = fwd_mask;
			end
			sfmp_pkg::SFMP_CLS_UNK_UCAST,
			sfmp_pkg::SFMP_CLS_UNK_MCAST,
			sfmp_pkg::SFMP_CLS_NORMAL: begin
				frame_mask = 3'h7;
			end
		endcase
		if (frame_drop) begin
			frame_mask = 3'h0;
		end
	end

	// The decision is registered, so it follows its descriptor by one cycle.
	always_comb begin
		frame_dec.valid     = frame.valid;
		frame_dec.drop      = frame_drop;
		frame_dec.cls       = frame_cls;
		frame_dec.port_mask = frame_mask;
	end

	// Bus, configuration and counter state.
	always_comb begin
		next_state        = state;
		next_state.ready  = setup;
		next_state.slverr = 1'b0;
		next_state.dec    = frame_dec;
		if (setup) begin
			next_state.rdata  = rd_word;
			next_state.slverr = rd_err;
		end
		if (wr_ctrl0) begin
			next_state.ctrl0 = pwdata[7:0];
		end
		if (wr_unk_vlan) begin
			next_state.unk_vlan = wr_data & sfmp_pkg::UNK_VLAN_WMASK;
		end
		if (wr_ctrl1) begin
			next_state.ctrl1 = pwdata[7:0];
		end
		// The count wraps, so software should work with differences between reads.
		if (frame.valid && frame_drop) begin
			next_state.drop_count = state.drop_count + 16'h0001;
		end
	end

	// Reset loads the register defaults; all other state starts at zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= '0;
			state.ctrl0 <= sfmp_pkg::CTRL0_RESET;
			state.ctrl1 <= sfmp_pkg::CTRL1_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Every port gets the same settings; only its duplex and collision count differ.
	// Port 1.
	sfmp_port_ctl u_port1 (
		.pclk         (pclk),
		.presetn      (presetn),
		.alt_backoff  (alt_backoff),
		.aggr_backoff (aggr_backoff),
		.no_exc_drop  (no_exc_drop),
		.half_duplex  (hd_p1),
		.coll_count   (coll_p1),
		.mac          (mac[0])
	);

	// Port 2.
	sfmp_port_ctl u_port2 (
		.pclk         (pclk),
		.presetn      (presetn),
		.alt_backoff  (alt_backoff),
		.aggr_backoff (aggr_backoff),
		.no_exc_drop  (no_exc_drop),
		.half_duplex  (hd_p2),
		.coll_count   (coll_p2),
		.mac          (mac[1])
	);

	// Port 3.
	sfmp_port_ctl u_port3 (
		.pclk         (pclk),
		.presetn      (presetn),
		.alt_backoff  (alt_backoff),
		.aggr_backoff (aggr_backoff),
		.no_exc_drop  (no_exc_drop),
		.half_duplex  (hd_p3),
		.coll_count   (coll_p3),
		.mac          (mac[2])
	);

	// Outputs come straight from the state register.
	assign prdata  = state.rdata;
	assign pready  = state.ready;
	assign pslverr = state.slverr;
	assign dec     = state.dec;
endmodule

// File: rtl/sfmp_pkg.sv
// Package with register map, field layout and carrier types for the forwarding policy block.
package sfmp_pkg;
	localparam logic [11:0] ADDR_MAC_CTRL0    = 12'h330;
	localparam logic [11:0] ADDR_UNK_VLAN     = 12'h328;
	localparam logic [11:0] ADDR_MAC_CTRL1    = 12'h334;
	localparam logic [11:0] ADDR_STATUS       = 12'h338;
	localparam logic [7:0]  CTRL0_RESET       = 8'h0E;
	localparam logic [7:0]  CTRL1_RESET       = 8'h00;
	localparam logic [31:0] UNK_VLAN_WMASK    = 32'h80000007;
	localparam int          BIT_ALT_BACKOFF   = 7;
	localparam int          BIT_LEN_CHECK     = 3;
	localparam int          BIT_FC_DROP_MODE  = 1;
	localparam int          BIT_AGGR_BACKOFF  = 0;
	localparam int          BIT_UNK_VLAN_EN   = 31;
	localparam int          BIT_NO_EXC_DROP   = 0;
	localparam logic [15:0] PAUSE_ETHERTYPE   = 16'h8808;
	localparam logic [47:0] PAUSE_DA          = 48'h0180C2000001;
	localparam logic [15:0] LEN_FIELD_LIMIT   = 16'h05DC;
	localparam logic [4:0]  EXC_COLLISIONS    = 5'h10;

	typedef enum logic [1:0] {
		SFMP_CLS_NORMAL,
		SFMP_CLS_UNK_VLAN,
		SFMP_CLS_UNK_UCAST,
		SFMP_CLS_UNK_MCAST
	} sfmp_cls_t;

	// Frame descriptor from the ingress parser.
	typedef struct packed {
		logic        valid;
		logic        unk_vlan;
		logic        unk_ucast;
		logic        unk_mcast;
		logic [15:0] type_len;
		logic [15:0] act_len;
		logic [47:0] da;
	} sfmp_frame_t;

	// Decision returned to the datapath.
	typedef struct packed {
		logic        valid;
		logic        drop;
		sfmp_cls_t   cls;
		logic [2:0]  port_mask;
	} sfmp_dec_t;

	// Per-port MAC transmit controls.
	typedef struct packed {
		logic alt_backoff;
		logic aggr_backoff;
		logic exc_drop;
	} sfmp_mac_t;
endpackage

// File: rtl/sfmp_port_ctl.sv
// Per-port back-off and collision drop control.
`timescale 1ns/1ns
module sfmp_port_ctl (
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Settings and port state.
	input  wire logic              alt_backoff,
	input  wire logic              aggr_backoff,
	input  wire logic              no_exc_drop,
	input  wire logic              half_duplex,
	input  wire logic [4:0]        coll_count,
	// Controls to the MAC.
	output sfmp_pkg::sfmp_mac_t    mac
);
	sfmp_pkg::sfmp_mac_t state;
	sfmp_pkg::sfmp_mac_t next_state;

	always_comb begin
		next_state.alt_backoff  = alt_backoff & half_duplex;
		next_state.aggr_backoff = aggr_backoff & half_duplex;
		next_state.exc_drop     = !no_exc_drop && (coll_count >= sfmp_pkg::EXC_COLLISIONS);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign mac = state;
endmodule

// File: test/sfmp_top_props.sv
// Assertions on the ports of the forwarding policy block.
`timescale 1ns/1ns
module sfmp_top_chk (
	// Clock, reset and bus.
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic [11:0]   paddr,
	input wire logic          pready,
	input wire logic          pslverr,
	// Frames and port state.
	input sfmp_pkg::sfmp_frame_t frame,
	input sfmp_pkg::sfmp_dec_t   dec,
	input wire logic [2:0]    half_duplex,
	input wire logic [14:0]   coll_count,
	input sfmp_pkg::sfmp_mac_t [2:0] mac
);
	logic mapped;
	assign mapped = paddr inside {12'h328, 12'h330, 12'h334, 12'h338};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_pause;
		frame.valid && frame.type_len == 16'h8808 && frame.da == 48'h0180C2000001;
	endsequence
	a_ready_next: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	a_dec_next: assert property (frame.valid |=> dec.valid)
		else $error("decision missing");
	a_drop_clear: assert property (dec.valid && dec.drop |-> dec.port_mask == 3'h0)
		else $error("dropped frame has ports");
	a_pause_both: assert property (s_pause |=> dec.drop)
		else $error("pause frame not dropped");
	a_vlan_first: assert property (frame.valid && frame.unk_vlan |=> dec.cls == 2'h1)
		else $error("vlan class not first");
	a_full_duplex: assert property (!half_duplex[0] |=> !mac[0].alt_backoff && !mac[0].aggr_backoff)
		else $error("back-off on full duplex");
	a_coll_low: assert property (coll_count[4:0] < 5'h10 |=> !mac[0].exc_drop)
		else $error("drop below sixteen collisions");
endmodule

// File: test/sfmp_top_test.sv
// Self-checking bench for the forwarding policy block.
`timescale 1ns/1ns
module sfmp_top_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, e;
	logic [47:0] ra;
	logic        dr;
	logic [7:0]  c0 = 8'h0E, k0;
	logic        c1 = 0, k1, kr = 0;
	logic [2:0]  khd;
	logic [14:0] kcc;
	logic [8:0]  xm;
	sfmp_pkg::sfmp_frame_t frame = '0;
	sfmp_pkg::sfmp_dec_t   dec;
	logic [2:0]  half_duplex = 0;
	logic [14:0] coll_count = 0;
	sfmp_pkg::sfmp_mac_t [2:0] mac;
	logic [3:0]  q[$];
	int mismatches = 0, n_compared = 0, seed = 4641;
	always #5 pclk = ~pclk;
	sfmp_top u_dut (.*);
	task complete_run;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] x, input logic [31:0] y);
		n_compared++;
		if (x !== y) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", s, x, y);
		end
	endtask
	// The request stays put until pready is seen high at an edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		frame.valid <= 0;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		if (w && a == 12'h330) c0 <= d[7:0];
		if (w && a == 12'h334) c1 <= d[0];
		if (n >= 20) begin
			mismatches++;
			complete_run;
		end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(0, a, 0);
		chk("rdata", x, r);
	endtask
	task fr(input logic uv, input logic [15:0] t, l, input logic [3:0] x);
		@(posedge pclk);
		ra = {16'($random(seed)), 32'($random(seed))};
		frame <= {1'b1, {3{uv}}, t, l, ra};
		q.push_back(x);
	endtask
	always @(posedge pclk) begin
		half_duplex <= 3'($random(seed));
		coll_count <= 15'($random(seed));
		{kr, k1, k0, khd, kcc} <= {presetn, c1, c0, half_duplex, coll_count};
		if (kr === 1'b1) begin
			for (int k = 0; k < 3; k++) begin
				xm[k*3 +: 3] = {k0[7] & khd[k], k0[0] & khd[k], !k1 && kcc[k*5 +: 5] >= 5'h10};
			end
			chk("mac", {23'h0, xm}, {23'h0, mac});
		end
		if (dec.valid === 1'b1) begin
			if (q.size() == 0) chk("extra", 0, 1);
			else chk("decision", {28'h0, q.pop_front()}, {28'h0, dec.drop, dec.port_mask});
		end
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rd(12'h330, 32'h0E);
		rd(12'h328, 32'h0);
		rd(12'h33C, 32'h0);
		chk("slverr", 1, e);
		fr(1, 16'h0800, 16'h0040, 4'h8);
		apb(1, 12'h328, 32'hFFFFFFFF);
		rd(12'h328, 32'h80000007);
		for (int m = 0; m < 8; m++) begin
			apb(1, 12'h328, {1'b1, 28'h0, 3'(m)});
			fr(1, 16'h0800, 16'h0040, {1'b0, 3'(m)});
		end
		// First half with drop mode set, second half with it clear.
		for (int i = 0; i < 8; i++) begin
			if (i == 4) apb(1, 12'h330, 32'h8D);
			dr = i[2] ? (i[1] & i[0]) : (i[1] | i[0]);
			fr(0, i[1] ? 16'h8808 : 16'h0800, 16'h0040, {dr, dr ? 3'h0 : 3'h7});
			if (i[0]) frame.da <= 48'h0180C2000001;
		end
		rd(12'h330, 32'h8D);
		fr(0, 16'h0064, 16'h0065, 4'h8);
		fr(0, 16'h05DB, 16'h0010, 4'h8);
		fr(0, 16'h05DC, 16'h0010, 4'h7);
		apb(1, 12'h330, 32'h85);
		fr(0, 16'h0064, 16'h0065, 4'h7);
		apb(1, 12'h334, 32'h1);
		rd(12'h334, 32'h1);
		rd(12'h338, 32'h7);
		repeat (3) @(posedge pclk);
		chk("pending", 0, q.size());
		complete_run;
	end
endmodule
bind sfmp_top sfmp_top_chk u_chk (.*);
